// *** logic/mrim_cfg.svh ***
// offsets, field positions and reset values of the rx/mac interrupt block
`ifndef MRIM_CFG_SVH
`define MRIM_CFG_SVH

// register bus geometry
`define MRIM_ADDR_W 8
`define MRIM_DATA_W 32

// byte offsets of the register map, one aligned word each
`define MRIM_OFS_RX_RAW 8'h00
`define MRIM_OFS_RX_MASKED 8'h04
`define MRIM_OFS_RX_EN_SET 8'h08
`define MRIM_OFS_RX_EN_CLR 8'h0C
`define MRIM_OFS_MAC_RAW 8'h10
`define MRIM_OFS_MAC_MASKED 8'h14
`define MRIM_OFS_MAC_EN_SET 8'h18
`define MRIM_OFS_MAC_EN_CLR 8'h1C
`define MRIM_OFS_EVT_STATUS 8'h20
`define MRIM_OFS_EVT_MASK 8'h24

// source counts
`define MRIM_RX_CH 8
`define MRIM_MAC_SRC 2

// mac field positions
`define MRIM_STAT_BIT 0
`define MRIM_HOST_BIT 1

// event status / event mask layout
`define MRIM_EVT_RX_LSB 0
`define MRIM_EVT_STAT_BIT 8
`define MRIM_EVT_HOST_BIT 9
`define MRIM_EVT_ACC_BIT 10
`define MRIM_EVT_W 11

// reset values
`define MRIM_RST_WORD 32'h0000_0000

`endif

// *** logic/mrim_pkg.sv ***
// types and address decode shared by the rx/mac interrupt block
`include "mrim_cfg.svh"

package mrim_pkg;

   // one bus word
   typedef logic [`MRIM_DATA_W-1:0] mrim_word_t;

   // decoded register select, one-hot
   typedef enum logic [10:0] {
      SEL_NONE = 11'h000,
      SEL_RX_RAW = 11'h001,
      SEL_RX_MASKED = 11'h002,
      SEL_RX_EN_SET = 11'h004,
      SEL_RX_EN_CLR = 11'h008,
      SEL_MAC_RAW = 11'h010,
      SEL_MAC_MASKED = 11'h020,
      SEL_MAC_EN_SET = 11'h040,
      SEL_MAC_EN_CLR = 11'h080,
      SEL_EVT_STATUS = 11'h100,
      SEL_EVT_MASK = 11'h200
   } mrim_sel_t;

   // byte address to register select; unmapped gives none
   function automatic mrim_sel_t mrim_decode(
      input logic [`MRIM_ADDR_W-1:0] addr);
      mrim_sel_t sel;
      sel = SEL_NONE;
      case (addr)
         `MRIM_OFS_RX_RAW: sel = SEL_RX_RAW;
         `MRIM_OFS_RX_MASKED: sel = SEL_RX_MASKED;
         `MRIM_OFS_RX_EN_SET: sel = SEL_RX_EN_SET;
         `MRIM_OFS_RX_EN_CLR: sel = SEL_RX_EN_CLR;
         `MRIM_OFS_MAC_RAW: sel = SEL_MAC_RAW;
         `MRIM_OFS_MAC_MASKED: sel = SEL_MAC_MASKED;
         `MRIM_OFS_MAC_EN_SET: sel = SEL_MAC_EN_SET;
         `MRIM_OFS_MAC_EN_CLR: sel = SEL_MAC_EN_CLR;
         `MRIM_OFS_EVT_STATUS: sel = SEL_EVT_STATUS;
         `MRIM_OFS_EVT_MASK: sel = SEL_EVT_MASK;
         default: sel = SEL_NONE;
      endcase
      return sel;
   endfunction : mrim_decode

endpackage : mrim_pkg

// *** logic/mrim_en_if.sv ***
// set/clear strobes and shared enable bits between decode and an enable bank
`timescale 1ns/100ps

interface mrim_en_if #(
   parameter int W = 8
);
   logic set_wr;         // write-one-to-set strobe
   logic clr_wr;         // write-one-to-clear strobe
   logic [W-1:0] wr_bits; // written data bits
   logic [W-1:0] enable;  // current enable state

   // register decode side
   modport ctrl (output set_wr, output clr_wr, output wr_bits,
                 input enable);
   // storage side
   modport bank (input set_wr, input clr_wr, input wr_bits,
                 output enable);
endinterface : mrim_en_if

// *** logic/mrim_enable_bank.sv ***
// one enable bit per source, reached by a set and a clear register
`timescale 1ns/100ps

module mrim_enable_bank #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // strobes and enable state
   mrim_en_if.bank en
);

   // set and clear act on the same bits; zeros leave bits alone
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         en.enable <= '0;
      end else if (en.set_wr) begin
         en.enable <= en.enable | en.wr_bits;
      end else if (en.clr_wr) begin
         en.enable <= en.enable & ~en.wr_bits;
      end
   end

endmodule : mrim_enable_bank

// *** logic/mrim_event_status.sv ***
// sticky event bits cleared by writing one, with a mask and one irq line
`timescale 1ns/100ps

module mrim_event_status #(
   parameter int W = 11
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // one-cycle event pulses
   input wire logic [W-1:0] evt_pulse,
   // software writes
   input wire logic clr_wr,
   input wire logic mask_wr,
   input wire logic [W-1:0] wr_bits,
   // state and interrupt
   output logic [W-1:0] sticky,
   output logic [W-1:0] mask,
   output logic irq
);

   // sticky bits: a new event beats a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sticky <= '0;
      end else if (clr_wr) begin
         sticky <= (sticky & ~wr_bits) | evt_pulse;
      end else begin
         sticky <= sticky | evt_pulse;
      end
   end

   // mask is plain read/write storage
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mask <= '0;
      end else if (mask_wr) begin
         mask <= wr_bits;
      end
   end

   // level interrupt, registered so it is glitch free at the pin
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(sticky & mask);
      end
   end

endmodule : mrim_event_status

// *** logic/mrim_mac_rx_irq.sv ***
// receive-channel and mac-level interrupt enable, status and irq logic
//
// Behaviour
// [R01] rx clear write one disables that channel
// [R02] mac raw bit 1 shows host error
// [R03] mac raw bit 0 shows statistics pending
// [R04] mac masked bits are pending and enabled
// [R05] mac set write one enables source
// [R06] mac clear write one disables source
// [R07] status read-only; everything resets to zero
// [R08] rx set write one enables that channel
// [R09] rx raw bit n shows channel pending
// [R10] rx masked bit is pending and enabled
// [R11] set and clear share enables, read back
`timescale 1ns/100ps
`include "mrim_cfg.svh"

module mrim_mac_rx_irq #(
   parameter int RX_CH = `MRIM_RX_CH,
   parameter int MAC_SRC = `MRIM_MAC_SRC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // register port
   input wire logic [`MRIM_ADDR_W-1:0] addr,
   input wire logic [`MRIM_DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [`MRIM_DATA_W-1:0] rd_data,
   // pending conditions from the dma and statistics logic
   input wire logic [RX_CH-1:0] rx_chan_pending,
   input wire logic host_error_pending,
   input wire logic stats_pending,
   // interrupt outputs
   output logic irq,
   output logic [RX_CH-1:0] rx_chan_irq,
   output logic [MAC_SRC-1:0] mac_irq
);

   ////////////////////////////////////////////////////////////////////
   // declarations
   ////////////////////////////////////////////////////////////////////

   // decoded select of the current access
   mrim_pkg::mrim_sel_t sel;
   // raw pending vectors as seen this cycle
   logic [RX_CH-1:0] rx_raw;
   logic [MAC_SRC-1:0] mac_raw;
   // masked pending vectors
   logic [RX_CH-1:0] rx_masked;
   logic [MAC_SRC-1:0] mac_masked;
   // previous raw values, for rising-edge events
   logic [RX_CH-1:0] rx_raw_reg;
   logic [MAC_SRC-1:0] mac_raw_reg;
   // one-cycle event pulses into the sticky status
   logic [`MRIM_EVT_W-1:0] evt_pulse;
   // write to a read-only word, or any access to an unmapped one
   logic bad_access;
   // sticky event status and its mask
   logic [`MRIM_EVT_W-1:0] evt_sticky;
   logic [`MRIM_EVT_W-1:0] evt_mask;
   // interrupt from the event block, before the output flop
   logic evt_irq;
   // read mux result, registered into rd_data
   mrim_pkg::mrim_word_t rd_next;
   // registered output copies
   logic [`MRIM_DATA_W-1:0] rd_data_reg;
   logic irq_reg;
   logic [RX_CH-1:0] rx_chan_irq_reg;
   logic [MAC_SRC-1:0] mac_irq_reg;

   // enable banks: one for rx channels, one for mac sources
   mrim_en_if #(.W(RX_CH)) rx_en ();
   mrim_en_if #(.W(MAC_SRC)) mac_en ();

   ////////////////////////////////////////////////////////////////////
   // helpers
   ////////////////////////////////////////////////////////////////////

   // widen a narrow field to a bus word, upper bits read zero
   function automatic mrim_pkg::mrim_word_t zext(
      input logic [`MRIM_EVT_W-1:0] bits);
      mrim_pkg::mrim_word_t w;
      w = `MRIM_RST_WORD;
      w[`MRIM_EVT_W-1:0] = bits;
      return w;
   endfunction : zext

   ////////////////////////////////////////////////////////////////////
   // decode and pending views
   ////////////////////////////////////////////////////////////////////

   // one decode serves both the write and the read path
   assign sel = mrim_pkg::mrim_decode(addr);

   // [R09] rx raw view
   // taken straight from the sources, enables play no part
   assign rx_raw = rx_chan_pending;

   // [R02] host error raw bit
   // host error sits at its own bit, independent of its enable
   assign mac_raw[`MRIM_HOST_BIT] = host_error_pending;
   // [R03] statistics raw bit
   // statistics at bit zero, also ahead of any masking
   assign mac_raw[`MRIM_STAT_BIT] = stats_pending;

   // [R10] rx masked view
   assign rx_masked = rx_raw & rx_en.enable;
   // [R04] mac masked view
   assign mac_masked = mac_raw & mac_en.enable;

   ////////////////////////////////////////////////////////////////////
   // write strobes toward the enable banks
   ////////////////////////////////////////////////////////////////////

   // [R08] rx set strobe
   assign rx_en.set_wr = wr_en && (sel == mrim_pkg::SEL_RX_EN_SET);
   // [R01] rx clear strobe
   assign rx_en.clr_wr = wr_en && (sel == mrim_pkg::SEL_RX_EN_CLR);
   // only the low channel bits matter, the rest of the word is ignored
   assign rx_en.wr_bits = wr_data[RX_CH-1:0];

   // [R05] mac set strobe
   assign mac_en.set_wr = wr_en && (sel == mrim_pkg::SEL_MAC_EN_SET);
   // [R06] mac clear strobe
   assign mac_en.clr_wr = wr_en && (sel == mrim_pkg::SEL_MAC_EN_CLR);
   assign mac_en.wr_bits = wr_data[MAC_SRC-1:0];

   // [R11] shared rx enables
   // one storage bit per channel, both registers act on it
   mrim_enable_bank #(
      .W(RX_CH)
   ) u_rx_bank (
      .ref_clk(ref_clk),
      .srst(srst),
      .en(rx_en.bank)
   );

   // [R11] shared mac enables
   mrim_enable_bank #(
      .W(MAC_SRC)
   ) u_mac_bank (
      .ref_clk(ref_clk),
      .srst(srst),
      .en(mac_en.bank)
   );

   ////////////////////////////////////////////////////////////////////
   // access checking
   ////////////////////////////////////////////////////////////////////

   // raw and masked status words and unmapped offsets refuse writes; flag the attempt
   // so a driver bug shows up instead of vanishing silently
   always_comb begin
      bad_access = 1'b0;
      if (wr_en) begin
         case (sel)
            // [R07] status ignores writes
            mrim_pkg::SEL_RX_RAW,
            mrim_pkg::SEL_RX_MASKED,
            mrim_pkg::SEL_MAC_RAW,
            mrim_pkg::SEL_MAC_MASKED,
            mrim_pkg::SEL_NONE: begin
               bad_access = 1'b1;
            end
            default: begin
               bad_access = 1'b0;
            end
         endcase
      end else if (rd_en && (sel == mrim_pkg::SEL_NONE)) begin
         // reads of holes answer zero but are still noted
         bad_access = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // event detection
   ////////////////////////////////////////////////////////////////////

   // remember last raw values; a held condition raises one event only
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rx_raw_reg <= '0;
         mac_raw_reg <= '0;
      end else begin
         rx_raw_reg <= rx_raw;
         mac_raw_reg <= mac_raw;
      end
   end

   // rising edges of every pending source plus bad accesses
   always_comb begin
      evt_pulse = '0;
      evt_pulse[`MRIM_EVT_RX_LSB +: RX_CH] = rx_raw & ~rx_raw_reg;
      evt_pulse[`MRIM_EVT_STAT_BIT] = mac_raw[`MRIM_STAT_BIT] &
                                      ~mac_raw_reg[`MRIM_STAT_BIT];
      evt_pulse[`MRIM_EVT_HOST_BIT] = mac_raw[`MRIM_HOST_BIT] &
                                      ~mac_raw_reg[`MRIM_HOST_BIT];
      evt_pulse[`MRIM_EVT_ACC_BIT] = bad_access;
   end

   // sticky status, mask and the combined interrupt
   mrim_event_status #(
      .W(`MRIM_EVT_W)
   ) u_events (
      .ref_clk(ref_clk),
      .srst(srst),
      .evt_pulse(evt_pulse),
      .clr_wr(wr_en && (sel == mrim_pkg::SEL_EVT_STATUS)),
      .mask_wr(wr_en && (sel == mrim_pkg::SEL_EVT_MASK)),
      .wr_bits(wr_data[`MRIM_EVT_W-1:0]),
      .sticky(evt_sticky),
      .mask(evt_mask),
      .irq(evt_irq)
   );

   ////////////////////////////////////////////////////////////////////
   // read path
   ////////////////////////////////////////////////////////////////////

   // read mux; reserved bits and holes read as zero
   always_comb begin
      rd_next = `MRIM_RST_WORD;
      case (sel)
         // [R09] rx raw read
         mrim_pkg::SEL_RX_RAW: begin
            rd_next = zext(`MRIM_EVT_W'(rx_raw));
         end
         // [R10] rx masked read
         mrim_pkg::SEL_RX_MASKED: begin
            rd_next = zext(`MRIM_EVT_W'(rx_masked));
         end
         // [R11] rx enables readable at set and clear
         mrim_pkg::SEL_RX_EN_SET,
         mrim_pkg::SEL_RX_EN_CLR: begin
            rd_next = zext(`MRIM_EVT_W'(rx_en.enable));
         end
         // [R02] [R03] mac raw read
         mrim_pkg::SEL_MAC_RAW: begin
            rd_next = zext(`MRIM_EVT_W'(mac_raw));
         end
         // [R04] mac masked read
         mrim_pkg::SEL_MAC_MASKED: begin
            rd_next = zext(`MRIM_EVT_W'(mac_masked));
         end
         // [R11] mac enables readable at set and clear
         mrim_pkg::SEL_MAC_EN_SET,
         mrim_pkg::SEL_MAC_EN_CLR: begin
            rd_next = zext(`MRIM_EVT_W'(mac_en.enable));
         end
         // sticky event status
         mrim_pkg::SEL_EVT_STATUS: begin
            rd_next = zext(evt_sticky);
         end
         // event mask
         mrim_pkg::SEL_EVT_MASK: begin
            rd_next = zext(evt_mask);
         end
         default: begin
            rd_next = `MRIM_RST_WORD;
         end
      endcase
   end

   // read data stands only in the cycle after the strobe, else zero
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rd_data_reg <= `MRIM_RST_WORD;
      end else if (rd_en) begin
         rd_data_reg <= rd_next;
      end else begin
         rd_data_reg <= `MRIM_RST_WORD;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt outputs
   ////////////////////////////////////////////////////////////////////

   // [R07] outputs reset to zero
   // per-source lines follow the masked views one cycle late; the extra
   // flop costs a cycle of latency but keeps the pins glitch free
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rx_chan_irq_reg <= '0;
         mac_irq_reg <= '0;
      end else begin
         rx_chan_irq_reg <= rx_masked;
         mac_irq_reg <= mac_masked;
      end
   end

   // combined line: the event block already registers it once; this
   // second flop keeps every top output on a local register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= evt_irq;
      end
   end

   // drive ports from the flops
   assign rd_data = rd_data_reg;
   assign irq = irq_reg;
   assign rx_chan_irq = rx_chan_irq_reg;
   assign mac_irq = mac_irq_reg;

endmodule : mrim_mac_rx_irq

// *** tb/mrim_mac_rx_irq_properties.sv ***
// port-level assertions for the rx/mac interrupt enable and status block
`timescale 1ns/100ps
`include "mrim_cfg.svh"

module mrim_irq_props #(
   parameter int RX_CH = 8,
   parameter int MAC_SRC = 2
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // register port
   input wire logic [`MRIM_ADDR_W-1:0] addr,
   input wire logic [`MRIM_DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [`MRIM_DATA_W-1:0] rd_data,
   // pending conditions
   input wire logic [RX_CH-1:0] rx_chan_pending,
   input wire logic host_error_pending,
   input wire logic stats_pending,
   // interrupt outputs
   input wire logic irq,
   input wire logic [RX_CH-1:0] rx_chan_irq,
   input wire logic [MAC_SRC-1:0] mac_irq
);
   logic [RX_CH-1:0] rx_en_reg; // shadow of rx channel enables
   logic [MAC_SRC-1:0] mac_en_reg; // shadow of mac enables

   ////////////////////////////////////////////////////////////////////////
   // shadow follows set/clear writes; enables are not visible at the ports
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rx_en_reg <= '0;
         mac_en_reg <= '0;
      end else if (wr_en) begin
         case (addr)
            8'h08: rx_en_reg <= rx_en_reg | wr_data[RX_CH-1:0];
            8'h0C: rx_en_reg <= rx_en_reg & ~wr_data[RX_CH-1:0];
            8'h18: mac_en_reg <= mac_en_reg | wr_data[MAC_SRC-1:0];
            8'h1C: mac_en_reg <= mac_en_reg & ~wr_data[MAC_SRC-1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   // host enable written, then host pending held without a clear
   sequence s_host_on;
      wr_en && addr == 8'h18 && wr_data[1];
   endsequence
   sequence s_host_held;
      host_error_pending && !(wr_en && addr == 8'h1C && wr_data[1]);
   endsequence

   a_reset_all_zero: assert property (
      $fell(srst) |-> rd_data == 0 && irq == 0 && rx_chan_irq == 0
         && mac_irq == 0) else $error("outputs not zero after reset");
   a_rx_raw_read: assert property (
      rd_en && addr == 8'h00 |=> rd_data == 32'($past(rx_chan_pending)))
      else $error("rx raw read wrong");
   a_mac_raw_read: assert property (
      rd_en && addr == 8'h10 |=> rd_data ==
         32'($past({host_error_pending, stats_pending})))
      else $error("mac raw read wrong");
   a_rx_masked_read: assert property (
      rd_en && addr == 8'h04 |=> rd_data ==
         32'($past(rx_chan_pending & rx_en_reg)))
      else $error("rx masked read wrong");
   a_mac_masked_read: assert property (
      rd_en && addr == 8'h14 |=> rd_data ==
         32'($past({host_error_pending, stats_pending} & mac_en_reg)))
      else $error("mac masked read wrong");
   a_rx_en_readback: assert property (
      rd_en && (addr == 8'h08 || addr == 8'h0C) |=>
         rd_data == 32'($past(rx_en_reg)))
      else $error("rx enable readback wrong");
   a_mac_en_readback: assert property (
      rd_en && (addr == 8'h18 || addr == 8'h1C) |=>
         rd_data == 32'($past(mac_en_reg)))
      else $error("mac enable readback wrong");
   a_rx_irq_gate: assert property (
      rx_chan_irq == $past(rx_chan_pending & rx_en_reg))
      else $error("rx channel irq not pending and enabled");
   a_mac_irq_gate: assert property (
      mac_irq == $past({host_error_pending, stats_pending} & mac_en_reg))
      else $error("mac irq not pending and enabled");
   a_host_set_seq: assert property (
      s_host_on ##1 s_host_held |=> mac_irq[1])
      else $error("host irq missing after enable");
endmodule : mrim_irq_props

bind mrim_mac_rx_irq mrim_irq_props #(.RX_CH(RX_CH), .MAC_SRC(MAC_SRC))
   u_props (.ref_clk(ref_clk), .srst(srst), .addr(addr),
   .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
   .rx_chan_pending(rx_chan_pending),
   .host_error_pending(host_error_pending),
   .stats_pending(stats_pending), .irq(irq),
   .rx_chan_irq(rx_chan_irq), .mac_irq(mac_irq));

// *** tb/test_mac_rx_interrupt_mask_logic.sv ***
// self-checking bench for the rx/mac interrupt enable and status block
`timescale 1ns/100ps
`include "mrim_cfg.svh"

module test_mac_rx_interrupt_mask_logic;
   logic ref_clk = 1'b0; // 200 MHz
   logic srst = 1'b1; // held for 12 cycles
   logic [`MRIM_ADDR_W-1:0] addr = '0;
   logic [`MRIM_DATA_W-1:0] wr_data = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [`MRIM_DATA_W-1:0] rd_data;
   logic [7:0] rx_chan_pending = '0;
   logic host_error_pending = 1'b0;
   logic stats_pending = 1'b0;
   logic irq;
   logic [7:0] rx_chan_irq;
   logic [1:0] mac_irq;
   int err_total = 0; // mismatches
   int n_tests = 0; // comparisons

   always #2.5 ref_clk = ~ref_clk;

   mrim_mac_rx_irq dut_u (.ref_clk(ref_clk), .srst(srst), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .rx_chan_pending(rx_chan_pending),
      .host_error_pending(host_error_pending),
      .stats_pending(stats_pending), .irq(irq),
      .rx_chan_irq(rx_chan_irq), .mac_irq(mac_irq));

   ////////////////////////////////////////////////////////////////////////
   // every task is entered and left just after a rising edge
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one-cycle write, then one idle edge so strobes never re-rise in a step
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      @(posedge ref_clk);
   endtask : bus_wr

   // read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      chk(rd_data, exp);
      @(posedge ref_clk);
   endtask : bus_rd

   // bounded wait for the event line, sampled after the edge settles
   task automatic wait_irq(input logic lvl);
      for (int k = 0; k < 10; k++) begin
         @(posedge ref_clk);
         #1;
         if (irq === lvl) begin
            break;
         end
      end
      chk(32'(irq), 32'(lvl));
      @(posedge ref_clk);
   endtask : wait_irq

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int a = 0; a <= 8'h24; a += 4) begin
         bus_rd(8'(a), 32'h0);
      end
      bus_wr(8'h08, 32'hFF);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      bus_rd(8'h08, 32'h0);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_rx();
      rx_chan_pending <= 8'hFF;
      bus_wr(8'h08, 32'hFFFF_FFA5);
      bus_rd(8'h08, 32'h0000_00A5);
      bus_wr(8'h08, 32'h0);
      bus_wr(8'h0C, 32'h0000_0081);
      bus_wr(8'h0C, 32'h0);
      bus_rd(8'h0C, 32'h0000_0024);
      bus_rd(8'h00, 32'h0000_00FF);
      bus_rd(8'h04, 32'h0000_0024);
      #1;
      chk(32'(rx_chan_irq), 32'h24);
      @(posedge ref_clk);
      rx_chan_pending <= 8'h0;
      bus_wr(8'h0C, 32'hFF);
      $display("t_rx done");
   endtask : t_rx

   task automatic t_mac();
      host_error_pending <= 1'b1;
      bus_rd(8'h10, 32'h2);
      bus_rd(8'h14, 32'h0);
      bus_wr(8'h18, 32'h3);
      bus_rd(8'h14, 32'h2);
      bus_wr(8'h1C, 32'h1);
      host_error_pending <= 1'b0;
      stats_pending <= 1'b1;
      bus_rd(8'h10, 32'h1);
      bus_rd(8'h14, 32'h0);
      host_error_pending <= 1'b1;
      bus_wr(8'h10, 32'hFFFF_FFFF);
      bus_rd(8'h10, 32'h3);
      // zeros written to the set word must leave the enables alone
      bus_wr(8'h18, 32'h0);
      bus_rd(8'h18, 32'h2);
      bus_rd(8'h1C, 32'h2);
      #1;
      chk(32'(mac_irq), 32'h2);
      @(posedge ref_clk);
      // host enable cleared while both sources stay pending
      bus_wr(8'h1C, 32'h2);
      bus_rd(8'h14, 32'h0);
      bus_rd(8'h10, 32'h3);
      host_error_pending <= 1'b0;
      stats_pending <= 1'b0;
      bus_wr(8'h1C, 32'h3);
      $display("t_mac done");
   endtask : t_mac

   // sticky events: raise, mask, clear, and a bad access
   task automatic t_event();
      bus_wr(8'h20, 32'h7FF);
      bus_rd(8'h20, 32'h0);
      bus_wr(8'h24, 32'h100);
      bus_rd(8'h24, 32'h100);
      stats_pending <= 1'b1;
      wait_irq(1'b1);
      bus_rd(8'h20, 32'h100);
      bus_wr(8'h24, 32'h0);
      wait_irq(1'b0);
      bus_wr(8'h24, 32'h100);
      wait_irq(1'b1);
      bus_wr(8'h20, 32'h100);
      wait_irq(1'b0);
      bus_rd(8'h20, 32'h0);
      bus_rd(8'h28, 32'h0);
      bus_rd(8'h20, 32'h400);
      stats_pending <= 1'b0;
      bus_wr(8'h20, 32'h400);
      $display("t_event done");
   endtask : t_event

   ////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   initial begin
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      t_rx();
      t_mac();
      t_event();
      test_done();
   end

   // the tests need under two hundred cycles; ten thousand means a hang
   initial begin
      #50000;
      err_total++;
      test_done();
   end
endmodule : test_mac_rx_interrupt_mask_logic
